// ### hdl/rx_port_interrupt_enable.sv
// Per-receive-port interrupt enable, status and interrupt output
`include "rx_irq_consts.svh"
module rx_port_interrupt_enable (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register access from the control bus slave
  input wire rx_irq_pkg::reg_req_t req_i,
  output logic [7:0] rdata_o,
  // Reads of the receive-port state registers, one-cycle pulses
  input wire logic state_one_rd_i,
  input wire logic state_two_rd_i,
  // Receiver events, same clock
  input wire rx_irq_pkg::rx_events_t ev_i,
  // Interrupt, active high
  output logic irq_o
);
  logic [7:0] en_hi_q;
  logic [7:0] en_lo_q;
  logic [7:0] st_hi_q;
  logic [7:0] st_lo_q;
  logic [7:0] st_hi_d;
  logic [7:0] st_lo_d;
  logic [7:0] rdata_d;
  logic irq_d;
  logic [7:0] set_hi;
  logic [7:0] set_lo;
  logic [7:0] clr_hi;
  logic [7:0] clr_lo;
  logic [7:0] en_hi_d;
  logic [7:0] en_lo_d;

  // Address decode shared by the write strobes and the read mux
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  wire wr_en_hi = req_i.wr && hit(req_i.addr, `ADDR_IRQ_EN_HIGH);
  wire wr_en_lo = req_i.wr && hit(req_i.addr, `ADDR_IRQ_EN_LOW);

  // Next enables; reserved bits are masked off so they can never be set
  assign en_hi_d = wr_en_hi ? (req_i.wdata & `EN_HIGH_MASK) : en_hi_q;
  assign en_lo_d = wr_en_lo ? (req_i.wdata & `EN_LOW_MASK) : en_lo_q;

  // Event set vectors placed at the enable bit positions
  assign set_hi = {5'h00, ev_i.link_coding_fault, ev_i.ctrl_chan_sequence_fault,
                   ev_i.ctrl_chan_check_fault};
  assign set_lo = {1'b0, ev_i.line_length_change, ev_i.line_count_change, ev_i.rx_buffer_overflow,
                   1'b0, ev_i.link_parity_fault, ev_i.port_valid_change,
                   ev_i.lock_change};

  // Which status bits each state register read clears; coding, length, count, buffer live in two
  assign clr_hi = {5'h00, state_two_rd_i, state_one_rd_i, state_one_rd_i};
  assign clr_lo = {1'b0, state_two_rd_i, state_two_rd_i, state_two_rd_i,
                   1'b0, state_one_rd_i, state_one_rd_i, state_one_rd_i};

  // Set wins over clear so an event in the clearing cycle is kept
  assign st_hi_d = (st_hi_q & ~clr_hi) | set_hi;
  assign st_lo_d = (st_lo_q & ~clr_lo) | set_lo;

  // Interrupt from next status and next enables, so the output never lags the pairs it reflects
  assign irq_d = |((st_hi_d & en_hi_d) | (st_lo_d & en_lo_d));

  // Read mux; unmapped addresses read zero
  assign rdata_d = hit(req_i.addr, `ADDR_IRQ_EN_HIGH) ? en_hi_q :
                   hit(req_i.addr, `ADDR_IRQ_EN_LOW) ? en_lo_q :
                   hit(req_i.addr, `ADDR_IRQ_ST_HIGH) ? st_hi_q :
                   hit(req_i.addr, `ADDR_IRQ_ST_LOW) ? st_lo_q : 8'h00;

  // Enable registers; reserved high bits stay zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_hi_q <= `EN_RESET;
      en_lo_q <= `EN_RESET;
    end else begin
      en_hi_q <= en_hi_d;
      en_lo_q <= en_lo_d;
    end
  end

  // Status, read data and interrupt registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_hi_q <= 8'h00;
      st_lo_q <= 8'h00;
      rdata_o <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      st_hi_q <= st_hi_d;
      st_lo_q <= st_lo_d;
      rdata_o <= req_i.rd ? rdata_d : 8'h00;
      irq_o <= irq_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence lock_ev_s;
    ev_i.lock_change && en_lo_d[`BIT_LOCK];
  endsequence

  lock_irq_a: assert property (lock_ev_s |=> irq_o && st_lo_q[`BIT_LOCK])
    else $error("lock change did not raise interrupt");
  coding_irq_a: assert property (ev_i.link_coding_fault && en_hi_d[`BIT_CODING] |=> irq_o)
    else $error("coding fault did not raise interrupt");
  seq_irq_a: assert property (ev_i.ctrl_chan_sequence_fault && en_hi_d[`BIT_SEQ] |=> irq_o)
    else $error("sequence fault did not raise interrupt");
  crc_irq_a: assert property (ev_i.ctrl_chan_check_fault && en_hi_d[`BIT_CRC] |=> irq_o)
    else $error("crc fault did not raise interrupt");
  len_irq_a: assert property (ev_i.line_length_change && en_lo_d[`BIT_LINE_LEN] |=> irq_o)
    else $error("line length change did not raise interrupt");
  cnt_irq_a: assert property (ev_i.line_count_change && en_lo_d[`BIT_LINE_CNT] |=> irq_o)
    else $error("line count change did not raise interrupt");
  ovf_irq_a: assert property (ev_i.rx_buffer_overflow && en_lo_d[`BIT_BUF_OVF] |=> irq_o)
    else $error("overflow did not raise interrupt");
  par_irq_a: assert property (ev_i.link_parity_fault && en_lo_d[`BIT_PARITY] |=> irq_o)
    else $error("parity fault did not raise interrupt");
  valid_irq_a: assert property (ev_i.port_valid_change && en_lo_d[`BIT_VALID] |=> irq_o)
    else $error("valid change did not raise interrupt");
  reserved_zero_a: assert property (en_hi_q[7:3] == 5'h00)
    else $error("reserved enable bits set");
  clear_read_a: assert property (state_one_rd_i && !ev_i.lock_change |=> !st_lo_q[`BIT_LOCK])
    else $error("state read did not clear lock status");
  irq_quiet_a: assert property (((st_hi_q & en_hi_q) == 8'h00) && ((st_lo_q & en_lo_q) == 8'h00)
                                |-> !irq_o)
    else $error("interrupt without enabled status");
  set_wins_a: assert property (ev_i.lock_change && state_one_rd_i |=> st_lo_q[`BIT_LOCK])
    else $error("event lost in clearing cycle");
  hold_status_a: assert property (st_lo_q[`BIT_LINE_LEN] && !state_two_rd_i
                                  |=> st_lo_q[`BIT_LINE_LEN])
    else $error("status not latched");

  // Raised whenever some enabled pair is pending
  irq_raise_a: assert property (((st_hi_q & en_hi_q) != 8'h00) || ((st_lo_q & en_lo_q) != 8'h00)
                                |-> irq_o)
    else $error("enabled status without interrupt");

  // Reserved bits of enables and status never read back as one
  en_lo_rsvd_a: assert property ((en_lo_q & ~`EN_LOW_MASK) == 8'h00)
    else $error("reserved low enable bits set");
  st_hi_rsvd_a: assert property ((st_hi_q & ~`EN_HIGH_MASK) == 8'h00)
    else $error("reserved high status bits set");
  st_lo_rsvd_a: assert property ((st_lo_q & ~`ST_LOW_MASK) == 8'h00)
    else $error("reserved low status bits set");

  // Enable writes land masked, and enables hold between writes
  en_hi_wr_a: assert property (wr_en_hi
                               |=> en_hi_q == ($past(req_i.wdata) & `EN_HIGH_MASK))
    else $error("high enable write lost");
  en_lo_wr_a: assert property (wr_en_lo
                               |=> en_lo_q == ($past(req_i.wdata) & `EN_LOW_MASK))
    else $error("low enable write lost");
  en_hi_hold_a: assert property (!wr_en_hi |=> $stable(en_hi_q))
    else $error("high enable changed without write");
  en_lo_hold_a: assert property (!wr_en_lo |=> $stable(en_lo_q))
    else $error("low enable changed without write");

  // Read data follows the addressed register for one cycle, zero otherwise
  rdata_idle_a: assert property (!req_i.rd |=> rdata_o == 8'h00)
    else $error("read data outside a read");
  rd_en_hi_a: assert property (req_i.rd && hit(req_i.addr, `ADDR_IRQ_EN_HIGH)
                               |=> rdata_o == $past(en_hi_q))
    else $error("high enable read wrong");
  rd_en_lo_a: assert property (req_i.rd && hit(req_i.addr, `ADDR_IRQ_EN_LOW)
                               |=> rdata_o == $past(en_lo_q))
    else $error("low enable read wrong");
  rd_st_hi_a: assert property (req_i.rd && hit(req_i.addr, `ADDR_IRQ_ST_HIGH)
                               |=> rdata_o == $past(st_hi_q))
    else $error("high status read wrong");
  rd_st_lo_a: assert property (req_i.rd && hit(req_i.addr, `ADDR_IRQ_ST_LOW)
                               |=> rdata_o == $past(st_lo_q))
    else $error("low status read wrong");

  // Coding fault: set by its event, held, cleared by the second state read
  coding_set_a: assert property (ev_i.link_coding_fault
                                 |=> st_hi_q[`BIT_CODING])
    else $error("coding status not set");
  coding_hold_a: assert property (st_hi_q[`BIT_CODING] && !state_two_rd_i
                                  |=> st_hi_q[`BIT_CODING])
    else $error("coding status not held");
  coding_clr_a: assert property (state_two_rd_i && !ev_i.link_coding_fault
                                 |=> !st_hi_q[`BIT_CODING])
    else $error("coding status not cleared");

  // Sequence fault: cleared by the first state read
  seq_set_a: assert property (ev_i.ctrl_chan_sequence_fault
                              |=> st_hi_q[`BIT_SEQ])
    else $error("sequence status not set");
  seq_hold_a: assert property (st_hi_q[`BIT_SEQ] && !state_one_rd_i
                               |=> st_hi_q[`BIT_SEQ])
    else $error("sequence status not held");
  seq_clr_a: assert property (state_one_rd_i && !ev_i.ctrl_chan_sequence_fault
                              |=> !st_hi_q[`BIT_SEQ])
    else $error("sequence status not cleared");

  // Check fault: cleared by the first state read
  crc_set_a: assert property (ev_i.ctrl_chan_check_fault
                              |=> st_hi_q[`BIT_CRC])
    else $error("crc status not set");
  crc_hold_a: assert property (st_hi_q[`BIT_CRC] && !state_one_rd_i
                               |=> st_hi_q[`BIT_CRC])
    else $error("crc status not held");
  crc_clr_a: assert property (state_one_rd_i && !ev_i.ctrl_chan_check_fault
                              |=> !st_hi_q[`BIT_CRC])
    else $error("crc status not cleared");

  // Line length change: cleared by the second state read
  len_set_a: assert property (ev_i.line_length_change
                              |=> st_lo_q[`BIT_LINE_LEN])
    else $error("line length status not set");
  len_clr_a: assert property (state_two_rd_i && !ev_i.line_length_change
                              |=> !st_lo_q[`BIT_LINE_LEN])
    else $error("line length status not cleared");

  // Line count change: cleared by the second state read
  cnt_set_a: assert property (ev_i.line_count_change
                              |=> st_lo_q[`BIT_LINE_CNT])
    else $error("line count status not set");
  cnt_hold_a: assert property (st_lo_q[`BIT_LINE_CNT] && !state_two_rd_i
                               |=> st_lo_q[`BIT_LINE_CNT])
    else $error("line count status not held");
  cnt_clr_a: assert property (state_two_rd_i && !ev_i.line_count_change
                              |=> !st_lo_q[`BIT_LINE_CNT])
    else $error("line count status not cleared");

  // Buffer overflow: cleared by the second state read
  ovf_set_a: assert property (ev_i.rx_buffer_overflow
                              |=> st_lo_q[`BIT_BUF_OVF])
    else $error("overflow status not set");
  ovf_hold_a: assert property (st_lo_q[`BIT_BUF_OVF] && !state_two_rd_i
                               |=> st_lo_q[`BIT_BUF_OVF])
    else $error("overflow status not held");
  ovf_clr_a: assert property (state_two_rd_i && !ev_i.rx_buffer_overflow
                              |=> !st_lo_q[`BIT_BUF_OVF])
    else $error("overflow status not cleared");

  // Parity fault: cleared by the first state read
  par_set_a: assert property (ev_i.link_parity_fault
                              |=> st_lo_q[`BIT_PARITY])
    else $error("parity status not set");
  par_hold_a: assert property (st_lo_q[`BIT_PARITY] && !state_one_rd_i
                               |=> st_lo_q[`BIT_PARITY])
    else $error("parity status not held");
  par_clr_a: assert property (state_one_rd_i && !ev_i.link_parity_fault
                              |=> !st_lo_q[`BIT_PARITY])
    else $error("parity status not cleared");

  // Port valid change: cleared by the first state read
  valid_set_a: assert property (ev_i.port_valid_change
                                |=> st_lo_q[`BIT_VALID])
    else $error("valid status not set");
  valid_hold_a: assert property (st_lo_q[`BIT_VALID] && !state_one_rd_i
                                 |=> st_lo_q[`BIT_VALID])
    else $error("valid status not held");
  valid_clr_a: assert property (state_one_rd_i && !ev_i.port_valid_change
                                |=> !st_lo_q[`BIT_VALID])
    else $error("valid status not cleared");

  // Lock change: latched while the first state read is absent
  lock_set_a: assert property (ev_i.lock_change
                               |=> st_lo_q[`BIT_LOCK])
    else $error("lock status not set");
  lock_hold_a: assert property (st_lo_q[`BIT_LOCK] && !state_one_rd_i
                                |=> st_lo_q[`BIT_LOCK])
    else $error("lock status not held");

  // A read of the wrong state register leaves a pending status alone
  cross_keep_a: assert property (st_hi_q[`BIT_CODING] && state_one_rd_i && !state_two_rd_i
                                 |=> st_hi_q[`BIT_CODING])
    else $error("coding status cleared by wrong read");
  cross_keep2_a: assert property (st_lo_q[`BIT_LOCK] && state_two_rd_i && !state_one_rd_i
                                  |=> st_lo_q[`BIT_LOCK])
    else $error("lock status cleared by wrong read");
endmodule // rx_port_interrupt_enable

// ### hdl/rx_irq_consts.svh
// Register offsets, field positions and reset values of the port interrupt block
`ifndef RX_IRQ_CONSTS_SVH
`define RX_IRQ_CONSTS_SVH
`define ADDR_IRQ_EN_HIGH 8'hD8
`define ADDR_IRQ_EN_LOW 8'hD9
`define ADDR_IRQ_ST_HIGH 8'hDA
`define ADDR_IRQ_ST_LOW 8'hDB
`define EN_HIGH_MASK 8'h07
`define EN_LOW_MASK 8'h77
`define ST_LOW_MASK 8'h77
`define EN_RESET 8'h00
`define BIT_CODING 2
`define BIT_SEQ 1
`define BIT_CRC 0
`define BIT_LINE_LEN 6
`define BIT_LINE_CNT 5
`define BIT_BUF_OVF 4
`define BIT_PARITY 2
`define BIT_VALID 1
`define BIT_LOCK 0
`endif

// ### hdl/rx_irq_pkg.sv
// Types shared by the port interrupt block
package rx_irq_pkg;
  // Receive-port events, one-cycle pulses from the receiver
  typedef struct packed {
    logic link_coding_fault;
    logic ctrl_chan_sequence_fault;
    logic ctrl_chan_check_fault;
    logic line_length_change;
    logic line_count_change;
    logic rx_buffer_overflow;
    logic link_parity_fault;
    logic port_valid_change;
    logic lock_change;
  } rx_events_t;
  // Register access strobe bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// ### verification/rx_port_interrupt_enable_tb.sv
// Self-checking bench for the port interrupt block
module rx_port_interrupt_enable_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  rx_irq_pkg::reg_req_t req = '0;
  rx_irq_pkg::rx_events_t ev = '0;
  logic rd_one = 1'b0;
  logic rd_two = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic [7:0] hi_e;
  logic [7:0] lo_e;
  logic g;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  int lo_pos[6] = '{0, 1, 2, 4, 5, 6};
  rx_port_interrupt_enable dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata),
    .state_one_rd_i(rd_one), .state_two_rd_i(rd_two), .ev_i(ev), .irq_o(irq));
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compared %0d, failed %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Strobes rise just after an edge and drop after the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    req = '{1'b1, 1'b0, a, d};
    @(posedge clk_i) #1;
    req = '0;
  endtask
  // Read data stands for one cycle only, so it is looked at right away
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i) #1;
    req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i) #1;
    req = '0;
    chk($sformatf("reg %h", a), exp, rdata);
  endtask
  task automatic pulse(input logic [8:0] e, input logic one, input logic two);
    @(posedge clk_i) #1;
    ev = e;
    rd_one = one;
    rd_two = two;
    @(posedge clk_i) #1;
    ev = '0;
    rd_one = 1'b0;
    rd_two = 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    chk("irq", 8'h00, {7'h00, irq});
    for (int a = 8'hD8; a <= 8'hDC; a++) rd(a[7:0], 8'h00);
    wr(8'hD8, 8'hFF);
    wr(8'hD9, 8'hFF);
    wr(8'hDA, 8'hFF);
    rd(8'hD8, 8'h07);
    rd(8'hD9, 8'h77);
    rd(8'hDA, 8'h00);
    wr(8'hD8, 8'h00);
    wr(8'hD9, 8'h00);
    $display("reset and access test done");
    // Each event latches while masked, interrupts once enabled, clears by its own group; only high events are checked to survive the other group's read
    for (int k = 0; k < 9; k++) begin
      hi_e = (k >= 6) ? 8'h01 << (k - 6) : 8'h00;
      lo_e = (k < 6) ? 8'h01 << lo_pos[k] : 8'h00;
      g = k inside {3, 4, 5, 8};
      pulse(9'h001 << k, 1'b0, 1'b0);
      chk("irq", 8'h00, {7'h00, irq});
      rd(8'hDA, hi_e);
      rd(8'hDB, lo_e);
      wr(8'hD8, hi_e);
      wr(8'hD9, lo_e);
      rd(8'hDB, lo_e);
      chk("irq", 8'h01, {7'h00, irq});
      pulse(9'h000, g, ~g);
      rd(8'hDA, hi_e);
      pulse(9'h000, ~g, g);
      chk("irq", 8'h00, {7'h00, irq});
      rd(8'hDA, 8'h00);
      rd(8'hDB, 8'h00);
    end
    $display("event loop test done");
    // An event in the clearing cycle survives the clear
    wr(8'hD9, 8'h01);
    pulse(9'h001, 1'b0, 1'b0);
    pulse(9'h001, 1'b1, 1'b0);
    rd(8'hDB, 8'h01);
    chk("irq", 8'h01, {7'h00, irq});
    $display("clear race test done");
    end_of_test();
  end
endmodule // rx_port_interrupt_enable_tb
